// ==== pkg/swh_defs.svh ====
// Constant definitions for the sleep and wake handshake block.
`ifndef SWH_DEFS_SVH
`define SWH_DEFS_SVH

// =====================================================================
// Timing
// =====================================================================
`define SWH_CLK_PERIOD_PS   25000
`define SWH_IDLE_W          16
`define SWH_WAKE_SETTLE_NS  100
`define SWH_WAKE_SETTLE_CYC ((`SWH_WAKE_SETTLE_NS * 1000 + `SWH_CLK_PERIOD_PS - 1) / `SWH_CLK_PERIOD_PS)
`define SWH_EVT_W           16

// =====================================================================
// Reset values and power-down bit positions
// =====================================================================
`define SWH_WAKE_POL_RST    1'b0
`define SWH_RFPD_ALL        4'hF
`define SWH_RFPD_TX         0
`define SWH_RFPD_RX         1
`define SWH_RFPD_PLL        2
`define SWH_RFPD_PA         3

`endif

// ==== pkg/swh_pkg.sv ====
// Types shared by the sleep and wake handshake block.
package swh_pkg;

    typedef enum logic [1:0] {
        SWH_WAKE_PINS,
        SWH_WAKE_UART,
        SWH_WAKE_SPI
    } swh_mode_t;

    typedef enum logic [2:0] {
        SWH_OFF,
        SWH_AWAKE,
        SWH_SLEEP,
        SWH_EVENT,
        SWH_SETTLE
    } swh_state_t;

endpackage

// ==== rtl/swh_sync2.sv ====
// Two-stage synchroniser for a single asynchronous level.
`timescale 1ns/1ps
module swh_sync2 (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // Level
    input  wire logic async_in,
    input  wire logic rst_val,
    output logic      sync_out
);
    logic stage1;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1   <= 1'b1;
            sync_out <= 1'b1;
        end
        else if (clk_en)
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

    // The reset value is fixed high; rst_val is kept for documentation of intent only.
    logic unused_rst_val;
    assign unused_rst_val = rst_val;
endmodule // swh_sync2

// ==== rtl/swh_idle_timer.sv ====
// Counter that flags the serial select idle for a programmed time.
`timescale 1ns/1ps
`include "swh_defs.svh"
module swh_idle_timer (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    // Control
    input  wire logic                   enable,
    input  wire logic                   select_active,
    input  wire logic [`SWH_IDLE_W-1:0] idle_limit,
    // Result
    output logic                        idle_expired
);
    logic [`SWH_IDLE_W-1:0] count;
    wire                    at_limit = (count >= idle_limit);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count        <= '0;
            idle_expired <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!enable || select_active)
            begin
                count        <= '0;
                idle_expired <= 1'b0;
            end
            else if (!at_limit)
            begin
                count <= count + `SWH_IDLE_W'(1);
            end
            else
            begin
                idle_expired <= 1'b1;
            end
        end
    end
endmodule // swh_idle_timer

// ==== rtl/swh_power_seq.sv ====
// Sleep, wake and power sequencing control for the transceiver and baseband core.
`timescale 1ns/1ps
`include "swh_defs.svh"
module swh_power_seq (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    // Power pins
    input  wire logic                   reg_enable,
    // Wake pins from host
    input  wire logic                   device_wake_in,
    input  wire logic                   uart_rts_n,
    input  wire logic                   serial_select_n,
    // Configuration
    input  wire swh_pkg::swh_mode_t     wake_mode,
    input  wire logic                   wake_polarity,
    input  wire logic                   host_wake_polarity,
    input  wire logic                   refclk_req_polarity,
    input  wire logic                   sleep_enable,
    input  wire logic                   spi_idle_sleep_en,
    input  wire logic [`SWH_IDLE_W-1:0] spi_idle_time,
    input  wire logic [`SWH_EVT_W-1:0]  event_interval,
    input  wire logic [`SWH_EVT_W-1:0]  event_length,
    // Baseband requests
    input  wire logic                   sleep_cmd,
    input  wire logic                   session_active,
    input  wire logic                   lowpower_conn,
    input  wire logic                   host_attention,
    input  wire logic                   data_pending,
    input  wire logic                   host_asleep,
    input  wire logic                   low_power_osc_tick,
    input  wire logic [3:0]             pkt_rf_on,
    // Outputs to host
    output logic                        host_wake_out,
    output logic                        host_wake_oe,
    output logic                        uart_cts_n,
    output logic                        uart_cts_oe,
    output logic                        serial_attn,
    output logic                        serial_attn_oe,
    output logic                        refclk_req,
    output logic                        refclk_req_oe,
    // Power controls
    output logic                        core_clk_gate_n,
    output logic                        periph_power_en,
    output logic                        retention_en,
    output logic                        transports_idle,
    output logic [3:0]                  rf_power_down,
    output logic                        reinit_req,
    // Status
    output logic                        awake,
    output swh_pkg::swh_state_t         seq_state
);
    // =====================================================================
    // Input synchronisers
    // =====================================================================
    logic wake_pin_s;
    logic rts_s;
    logic select_n_s;
    logic reg_en_s;

    swh_sync2 u_sync_wake (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in (device_wake_in),
        .rst_val  (1'b1),
        .sync_out (wake_pin_s)
    );
    swh_sync2 u_sync_rts (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in (uart_rts_n),
        .rst_val  (1'b1),
        .sync_out (rts_s)
    );
    swh_sync2 u_sync_sel (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in (serial_select_n),
        .rst_val  (1'b1),
        .sync_out (select_n_s)
    );
    // Regulator enable is synchronised too; its reset value is low so that
    // leaving reset always walks through the power-up settle.
    logic reg_en_q1;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_en_q1 <= 1'b0;
            reg_en_s  <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_en_q1 <= reg_enable;
            reg_en_s  <= reg_en_q1;
        end
    end

    // =====================================================================
    // Wake request decode
    // =====================================================================
    logic wake_pol_q;
    // Polarity follows wake_polarity every cycle while powered; a regulator cycle returns it to active low.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            wake_pol_q <= `SWH_WAKE_POL_RST;
        else if (clk_en)
            wake_pol_q <= reg_en_s ? wake_polarity : `SWH_WAKE_POL_RST;
    end

    wire pin_wake   = (wake_pin_s == wake_pol_q);
    wire uart_wake  = !rts_s;
    wire spi_select = !select_n_s;
    wire host_wake_req = (wake_mode == swh_pkg::SWH_WAKE_PINS) ? pin_wake  :
                         (wake_mode == swh_pkg::SWH_WAKE_UART) ? uart_wake :
                         spi_select;

    // =====================================================================
    // SPI idle detection
    // =====================================================================
    logic spi_idle;
    wire  spi_mode = (wake_mode == swh_pkg::SWH_WAKE_SPI);

    swh_idle_timer u_idle (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .clk_en        (clk_en),
        .enable        (spi_mode && spi_idle_sleep_en),
        .select_active (spi_select),
        .idle_limit    (spi_idle_time),
        .idle_expired  (spi_idle)
    );

    // =====================================================================
    // Sleep criteria
    // =====================================================================
    // In SPI mode the idle timer stands in for the host command.
    wire sleep_wanted = spi_mode ? (spi_idle_sleep_en && spi_idle)
                                 : (sleep_enable && sleep_cmd);
    wire may_sleep = sleep_wanted && !host_wake_req;
    wire use_timer = session_active || lowpower_conn;

    // =====================================================================
    // Sequencer
    // =====================================================================
    swh_pkg::swh_state_t     state;
    swh_pkg::swh_state_t     next_state;
    logic [`SWH_EVT_W-1:0]   evt_cnt;
    logic [`SWH_EVT_W-1:0]   next_evt_cnt;
    localparam int           SETTLE_CYC = `SWH_WAKE_SETTLE_CYC;
    logic [7:0]              settle_cnt;
    wire                     tick = low_power_osc_tick;

    always_comb
    begin
        next_state   = state;
        next_evt_cnt = evt_cnt;
        unique case (state)
            swh_pkg::SWH_OFF:
                if (reg_en_s)
                    next_state = swh_pkg::SWH_SETTLE;
            swh_pkg::SWH_SETTLE:
                if (settle_cnt >= 8'(SETTLE_CYC))
                    next_state = swh_pkg::SWH_AWAKE;
            swh_pkg::SWH_AWAKE:
            begin
                next_evt_cnt = '0;
                if (may_sleep)
                    next_state = swh_pkg::SWH_SLEEP;
            end
            swh_pkg::SWH_SLEEP:
            begin
                if (host_wake_req)
                    next_state = swh_pkg::SWH_AWAKE;
                else if (use_timer && tick)
                begin
                    if (evt_cnt >= event_interval)
                    begin
                        next_evt_cnt = '0;
                        next_state   = swh_pkg::SWH_EVENT;
                    end
                    else
                        next_evt_cnt = evt_cnt + `SWH_EVT_W'(1);
                end
            end
            swh_pkg::SWH_EVENT:
            begin
                // A host wake during the event keeps the device up afterwards.
                if (host_wake_req || !may_sleep)
                    next_state = swh_pkg::SWH_AWAKE;
                else if (tick)
                begin
                    if (evt_cnt >= event_length)
                    begin
                        next_evt_cnt = '0;
                        next_state   = swh_pkg::SWH_SLEEP;
                    end
                    else
                        next_evt_cnt = evt_cnt + `SWH_EVT_W'(1);
                end
            end
            // Unused codes fall back to off and take the power-up path again.
            default:
                next_state = swh_pkg::SWH_OFF;
        endcase
        if (!reg_en_s)
            next_state = swh_pkg::SWH_OFF;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= swh_pkg::SWH_OFF;
            evt_cnt    <= '0;
            settle_cnt <= '0;
        end
        else if (clk_en)
        begin
            state      <= next_state;
            evt_cnt    <= next_evt_cnt;
            settle_cnt <= (state == swh_pkg::SWH_SETTLE) ? settle_cnt + 8'(1) : '0;
        end
    end

    // =====================================================================
    // Decoded power state
    // =====================================================================
    wire is_off    = (state == swh_pkg::SWH_OFF);
    wire is_sleep  = (state == swh_pkg::SWH_SLEEP);
    wire is_active = (state == swh_pkg::SWH_AWAKE) || (state == swh_pkg::SWH_EVENT);
    wire need_ref  = !is_off && !is_sleep;
    wire alert     = is_active && host_attention;
    wire spi_attn  = spi_mode && host_asleep && data_pending && !is_off;
    wire cts_wake  = is_active && host_attention;
    // RF blocks are only powered inside packet windows of an active state.
    wire [3:0] next_rfpd = is_active ? ~pkt_rf_on : `SWH_RFPD_ALL;

    // =====================================================================
    // Registered outputs
    // =====================================================================
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_wake_out   <= 1'b0;
            uart_cts_n      <= 1'b1;
            serial_attn     <= 1'b0;
            refclk_req      <= 1'b0;
            core_clk_gate_n <= 1'b0;
            periph_power_en <= 1'b0;
            retention_en    <= 1'b0;
            transports_idle <= 1'b1;
            rf_power_down   <= `SWH_RFPD_ALL;
            reinit_req      <= 1'b0;
        end
        else if (clk_en)
        begin
            host_wake_out   <= host_wake_polarity ? alert : !alert;
            uart_cts_n      <= !cts_wake;
            serial_attn     <= spi_attn;
            refclk_req      <= refclk_req_polarity ? need_ref : !need_ref;
            core_clk_gate_n <= is_active;
            periph_power_en <= is_active;
            retention_en    <= is_sleep;
            transports_idle <= !is_active;
            rf_power_down   <= next_rfpd;
            reinit_req      <= (state == swh_pkg::SWH_SETTLE);
        end
    end

    // Output enables drop during shutdown so every pin floats.
    assign host_wake_oe   = !is_off;
    assign uart_cts_oe    = !is_off && (wake_mode == swh_pkg::SWH_WAKE_UART);
    assign serial_attn_oe = !is_off && spi_mode;
    assign refclk_req_oe  = !is_off;
    assign awake          = is_active;
    assign seq_state      = state;
endmodule // swh_power_seq

// ==== tb/swh_power_seq_monitor.sv ====
// Port-level checker for the sleep and wake power sequencer.
`timescale 1ns/1ps
`include "swh_defs.svh"
module swh_power_seq_monitor (
    // Clock and reset
    input wire logic                ref_clk,
    input wire logic                rst_n,
    // Inputs seen
    input wire logic                reg_enable,
    input wire logic                device_wake_in,
    input wire logic                serial_select_n,
    input wire swh_pkg::swh_mode_t  wake_mode,
    input wire logic                wake_polarity,
    input wire logic                host_wake_polarity,
    input wire logic                refclk_req_polarity,
    input wire logic                host_attention,
    input wire logic                data_pending,
    input wire logic                host_asleep,
    // Outputs seen
    input wire logic                host_wake_out,
    input wire logic                host_wake_oe,
    input wire logic                serial_attn_oe,
    input wire logic                refclk_req_oe,
    input wire logic                serial_attn,
    input wire logic                refclk_req,
    input wire logic                periph_power_en,
    input wire logic                retention_en,
    input wire logic                transports_idle,
    input wire logic [3:0]          rf_power_down,
    input wire logic                reinit_req,
    input wire logic                awake,
    input wire swh_pkg::swh_state_t seq_state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // =========================================================
    // Properties
    // =========================================================
    property p_off_quiet;
        seq_state == swh_pkg::SWH_OFF |-> !(host_wake_oe | serial_attn_oe | refclk_req_oe);
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("Output enabled while powered off");
    property p_off_rf;
        (seq_state == swh_pkg::SWH_OFF) [*2] |-> rf_power_down == `SWH_RFPD_ALL;
    endproperty
    a_off_rf: assert property (p_off_rf)
        else $error("Radio sections not powered down while off");
    property p_drop;
        $fell(reg_enable) |-> ##[1:4] seq_state == swh_pkg::SWH_OFF;
    endproperty
    a_drop: assert property (p_drop)
        else $error("Regulator disable did not reach off state");
    property p_reinit;
        $rose(seq_state == swh_pkg::SWH_SETTLE) |-> ##[1:2] reinit_req;
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("No reinitialisation request after power up");
    property p_wake_hold;
        (wake_mode == swh_pkg::SWH_WAKE_PINS && device_wake_in == wake_polarity) [*4]
            |-> seq_state != swh_pkg::SWH_SLEEP;
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("Asleep while wake input asserted");
    property p_select_wake;
        (wake_mode == swh_pkg::SWH_WAKE_SPI && !serial_select_n) [*4]
            |-> seq_state != swh_pkg::SWH_SLEEP;
    endproperty
    a_select_wake: assert property (p_select_wake)
        else $error("Asleep while serial select asserted");
    property p_alert;
        (awake && host_attention) [*2] |-> host_wake_out == $past(host_wake_polarity);
    endproperty
    a_alert: assert property (p_alert)
        else $error("Host alert not asserted");
    property p_sleep_power;
        (seq_state == swh_pkg::SWH_SLEEP) [*2] |-> retention_en && !periph_power_en
            && transports_idle && refclk_req != $past(refclk_req_polarity);
    endproperty
    a_sleep_power: assert property (p_sleep_power)
        else $error("Sleep power controls wrong");
    property p_awake_clk;
        (seq_state == swh_pkg::SWH_AWAKE) [*2] |-> refclk_req == $past(refclk_req_polarity);
    endproperty
    a_awake_clk: assert property (p_awake_clk)
        else $error("Clock request missing while awake");
    property p_attn;
        (wake_mode == swh_pkg::SWH_WAKE_SPI && awake && host_asleep && data_pending) [*2]
            |-> serial_attn;
    endproperty
    a_attn: assert property (p_attn)
        else $error("Serial attention not raised");
endmodule // swh_power_seq_monitor

bind swh_power_seq swh_power_seq_monitor mon (.*);

// ==== tb/swh_host_model.sv ====
// Host processor model driving the wake request lines.
`timescale 1ns/1ps
module swh_host_model (
    // Clock
    input  wire logic               ref_clk,
    // Control from the bench
    input  wire swh_pkg::swh_mode_t wake_mode,
    input  wire logic               wake_polarity,
    input  wire logic               want_wake,
    // Lines to the device
    output logic                    device_wake_in,
    output logic                    uart_rts_n,
    output logic                    serial_select_n
);
    initial
    begin
        device_wake_in = 1'b1;
        uart_rts_n = 1'b1;
        serial_select_n = 1'b1;
    end

    // Only the line of the selected mode carries the request; the others rest deasserted.
    always @(posedge ref_clk)
    begin
        device_wake_in  <= (wake_mode == swh_pkg::SWH_WAKE_PINS && want_wake) ?
                           wake_polarity : !wake_polarity;
        uart_rts_n      <= !(wake_mode == swh_pkg::SWH_WAKE_UART && want_wake);
        serial_select_n <= !(wake_mode == swh_pkg::SWH_WAKE_SPI && want_wake);
    end
endmodule // swh_host_model

// ==== tb/sleep_wake_handshake_bench.sv ====
// Self-checking bench for the sleep and wake power sequencer.
`timescale 1ns/1ps
module sleep_wake_handshake_bench;
    logic        ref_clk, rst_n, clk_en, reg_enable, want_wake;
    logic        device_wake_in, uart_rts_n, serial_select_n;
    logic        wake_polarity, host_wake_polarity, refclk_req_polarity;
    logic        sleep_enable, sleep_cmd, spi_idle_sleep_en, session_active, lowpower_conn;
    logic        host_attention, data_pending, host_asleep, low_power_osc_tick;
    logic [15:0] spi_idle_time, event_interval, event_length;
    logic [3:0]  pkt_rf_on, rf_power_down;
    logic        host_wake_out, host_wake_oe, uart_cts_n, uart_cts_oe;
    logic        serial_attn, serial_attn_oe, refclk_req, refclk_req_oe;
    logic        core_clk_gate_n, periph_power_en, retention_en, transports_idle;
    logic        reinit_req, awake;
    logic [1:0]  tick_div;
    int          miscompares, compares, bad;
    swh_pkg::swh_mode_t  wake_mode;
    swh_pkg::swh_state_t seq_state;

    swh_power_seq dut (.*);
    swh_host_model host (.*);

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Oscillator tick every fourth cycle keeps timed wakes short.
    always @(posedge ref_clk)
    begin
        tick_div <= tick_div + 2'h1;
        low_power_osc_tick <= (tick_div == 2'h3);
    end

    // =========================================================
    // Helpers
    // =========================================================
    task automatic conclude;
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR time=%0t got=%0h expected=%0h", $time, got, exp);
        end
    endtask

    // Level that a polarity-selectable output shows for a wanted state.
    function automatic logic pol_level(input logic pol, input logic level);
        return pol ? level : !level;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wait_state(input swh_pkg::swh_state_t s, input int lim);
        int n;
        n = 0;
        while (seq_state !== s && n < lim)
        begin
            @(negedge ref_clk);
            n++;
        end
        check(16'(seq_state), 16'(s));
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        conclude();
    end

    // =========================================================
    // Tests
    // =========================================================
    initial
    begin
        void'($urandom(28785));
        {rst_n, clk_en, reg_enable, want_wake} = 4'b0111;
        wake_mode = swh_pkg::SWH_WAKE_PINS;
        {wake_polarity, host_wake_polarity, refclk_req_polarity} = 3'b011;
        {sleep_enable, sleep_cmd, spi_idle_sleep_en, session_active, lowpower_conn} = 5'h00;
        {host_attention, data_pending, host_asleep, low_power_osc_tick} = 4'h0;
        spi_idle_time = 16'h0004;
        event_interval = 16'h0003;
        event_length = 16'h0002;
        pkt_rf_on = 4'h0;
        tick_div = 2'h0;
        miscompares = 0;
        compares = 0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        cyc(1);
        check(rf_power_down, 4'hF);
        wait_state(swh_pkg::SWH_SETTLE, 10);
        cyc(2);
        check(reinit_req, 1'b1);
        wait_state(swh_pkg::SWH_AWAKE, 12);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge ref_clk);
            wake_mode <= swh_pkg::swh_mode_t'(i % 3);
            wake_polarity <= 1'($urandom);
            refclk_req_polarity <= 1'($urandom);
            pkt_rf_on <= 4'($urandom);
            cyc(6);
            check(refclk_req, pol_level(refclk_req_polarity, 1'b1));
            check({uart_cts_oe, serial_attn_oe}, {i % 3 == 1, i % 3 == 2});
            check(rf_power_down, 4'(~pkt_rf_on));
            @(posedge ref_clk);
            sleep_enable <= 1'b1;
            sleep_cmd <= (i % 3 != 2);
            spi_idle_sleep_en <= 1'b1;
            spi_idle_time <= 16'($urandom % 8 + 2);
            cyc(10);
            check(awake, 1'b1);
            check(core_clk_gate_n, 1'b1);
            @(posedge ref_clk);
            want_wake <= 1'b0;
            wait_state(swh_pkg::SWH_SLEEP, 40);
            cyc(2);
            check(retention_en, 1'b1);
            check(periph_power_en, 1'b0);
            check(core_clk_gate_n, 1'b0);
            check(transports_idle, 1'b1);
            check(refclk_req, pol_level(refclk_req_polarity, 1'b0));
            @(posedge ref_clk);
            want_wake <= 1'b1;
            wait_state(swh_pkg::SWH_AWAKE, 8);
            @(posedge ref_clk);
            sleep_cmd <= 1'b0;
            spi_idle_sleep_en <= 1'b0;
        end
        for (int k = 0; k < 2; k++)
        begin
            @(posedge ref_clk);
            wake_mode <= swh_pkg::SWH_WAKE_PINS;
            session_active <= (k == 0);
            lowpower_conn <= (k == 1);
            cyc(5);
            @(posedge ref_clk);
            sleep_cmd <= 1'b1;
            want_wake <= 1'b0;
            wait_state(swh_pkg::SWH_SLEEP, 20);
            wait_state(swh_pkg::SWH_EVENT, 80);
            wait_state(swh_pkg::SWH_SLEEP, 80);
            wait_state(swh_pkg::SWH_EVENT, 80);
            @(posedge ref_clk);
            want_wake <= 1'b1;
            wait_state(swh_pkg::SWH_AWAKE, 8);
            bad = 0;
            repeat (100)
            begin
                @(negedge ref_clk);
                if (seq_state !== swh_pkg::SWH_AWAKE)
                    bad++;
            end
            check(16'(bad), 16'h0000);
            @(posedge ref_clk);
            sleep_cmd <= 1'b0;
            {session_active, lowpower_conn} <= 2'b00;
        end
        @(posedge ref_clk);
        wake_mode <= swh_pkg::SWH_WAKE_UART;
        host_attention <= 1'b1;
        host_wake_polarity <= 1'($urandom);
        cyc(4);
        check(host_wake_out, pol_level(host_wake_polarity, 1'b1));
        check(uart_cts_n, 1'b0);
        @(posedge ref_clk);
        host_attention <= 1'b0;
        cyc(3);
        check(host_wake_out, pol_level(host_wake_polarity, 1'b0));
        check(uart_cts_n, 1'b1);
        @(posedge ref_clk);
        wake_mode <= swh_pkg::SWH_WAKE_SPI;
        {host_asleep, data_pending} <= 2'b11;
        cyc(5);
        check(serial_attn, 1'b1);
        @(posedge ref_clk);
        reg_enable <= 1'b0;
        wait_state(swh_pkg::SWH_OFF, 6);
        cyc(1);
        check({host_wake_oe, uart_cts_oe, serial_attn_oe, refclk_req_oe}, 4'h0);
        check(rf_power_down, 4'hF);
        @(posedge ref_clk);
        reg_enable <= 1'b1;
        wait_state(swh_pkg::SWH_SETTLE, 6);
        wait_state(swh_pkg::SWH_AWAKE, 12);
        conclude();
    end
endmodule // sleep_wake_handshake_bench
